// ### rtl/rtc_calendar_regs.sv
// rtc_calendar_regs: two-wire slave and register map of the clock/calendar
// assumes: scl, sda and monitors async to ref_clk; events are ref_clk pulses
`timescale 1ns/10ps

module rtc_calendar_regs
    import rtc_pkg::*;
#(
    parameter logic [SLAVE_ADDR_W-1:0] SLAVE_ADDR = 7'h51  // bus address of this device
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // oscillator and supply monitors
    input wire logic osc_stopped_in,
    input wire logic supply_low_in,
    // timekeeping events
    input wire logic alarm_match,
    input wire logic timer_expired,
    // interrupt pin, open drain, low when driven
    output logic int_out,
    output logic int_oe,
    // control bits to the timekeeping logic
    output logic divider_clear,
    output logic factory_test,
    output logic factory_test_c_bit,
    output logic timer_irq_level_or_pulse,
    output logic [3:0] alarm_condition_enable,
    output logic clock_output_disable,
    output logic [1:0] clock_output_freq_sel,
    output logic timer_enable_bit,
    output logic [1:0] timer_source_sel,
    output logic [7:0] timer_countdown_value
);

    // byte engine states
    typedef enum logic [3:0] {
        ST_IDLE,        // waiting for a start
        ST_ADDR,        // shifting in the slave address byte
        ST_ADDR_ACK,    // acknowledging our address
        ST_WORD,        // shifting in the register pointer
        ST_WORD_ACK,    // acknowledging the pointer
        ST_WDATA,       // shifting in a data byte
        ST_WDATA_ACK,   // acknowledging a data byte
        ST_RDATA,       // shifting out a data byte
        ST_RACK,        // sampling the master acknowledge
        ST_WAIT         // not addressed or nack; ignore until start or stop
    } rtc_state_t;

    // filtered pins and edge history
    logic scl_s;        // filtered clock line
    logic sda_s;        // filtered data line
    logic osc_stop_s;   // filtered oscillator-stopped level
    logic vlow_s;       // filtered supply-low level
    logic scl_prev_q;   // clock line one cycle ago
    logic sda_prev_q;   // data line one cycle ago

    // decoded bus events
    logic scl_rise;     // clock line went high
    logic scl_fall;     // clock line went low
    logic start_det;    // data fell while clock high
    logic stop_det;     // data rose while clock high
    logic core_rst;     // external reset or stopped oscillator

    // engine state
    rtc_state_t state_q;
    rtc_state_t state_d;
    logic [3:0] bit_cnt_q;  // bits seen in the current byte
    logic [3:0] bit_cnt_d;
    logic [7:0] rx_q;       // receive shifter
    logic [7:0] tx_q;       // transmit shifter
    logic [7:0] tx_d;
    logic [3:0] ptr_q;      // register pointer
    logic [3:0] ptr_d;
    logic rw_q;             // read when high, taken from the address byte
    logic sda_oe_q;         // registered data-line pull-down
    logic int_oe_q;         // registered interrupt pull-down
    logic byte_full;        // eight bits received
    logic addr_hit;         // received address is ours

    // register image from the bank
    logic [15:0][7:0] regs_q;

    rtc_reg_if reg_bus ();

    // line synchronisers; idle bus lines are high
    rtc_pin_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw_in  (scl_in),
        .level_q (scl_s)
    );

    rtc_pin_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw_in  (sda_in),
        .level_q (sda_s)
    );

    // monitors reset to the quiet level
    rtc_pin_sync #(.RST_VAL(1'b0)) u_sync_osc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw_in  (osc_stopped_in),
        .level_q (osc_stop_s)
    );

    rtc_pin_sync #(.RST_VAL(1'b0)) u_sync_vlow (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw_in  (supply_low_in),
        .level_q (vlow_s)
    );

    // a stopped oscillator holds all but the pin synchronisers in reset
    assign core_rst = rst | osc_stop_s;

    // edge history of the filtered lines
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // bus event decode; both lines are filtered so start/stop never alias a bit
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign byte_full = (bit_cnt_q == BITS_PER_BYTE);
    assign addr_hit = (rx_q[7:1] == SLAVE_ADDR);

    // next state, bit count, pointer and transmit byte
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        ptr_d = ptr_q;
        tx_d = tx_q;
        if (start_det) begin
            // also a repeated start
            state_d = ST_ADDR;
            bit_cnt_d = 4'h0;
        end else if (stop_det) begin
            state_d = ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_WAIT: begin
                    state_d = state_q;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && byte_full) begin
                        state_d = addr_hit ? ST_ADDR_ACK : ST_WAIT;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        if (rw_q) begin
                            // first read byte comes from the current pointer
                            state_d = ST_RDATA;
                            tx_d = reg_bus.rdata;
                            ptr_d = ptr_q + 4'h1;
                        end else begin
                            state_d = ST_WORD;
                        end
                    end
                end
                ST_WORD: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && byte_full) begin
                        // upper pointer bits have no register behind them
                        state_d = ST_WORD_ACK;
                        ptr_d = rx_q[3:0];
                    end
                end
                ST_WORD_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_d = ST_WDATA;
                        bit_cnt_d = 4'h0;
                    end
                end
                ST_WDATA: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && byte_full) begin
                        state_d = ST_WDATA_ACK;
                        ptr_d = ptr_q + 4'h1;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q == BITS_PER_BYTE - 4'h1) begin
                            state_d = ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda_s) begin
                        // master nack ends the read
                        state_d = ST_WAIT;
                    end else if (scl_fall) begin
                        state_d = ST_RDATA;
                        bit_cnt_d = 4'h0;
                        tx_d = reg_bus.rdata;
                        ptr_d = ptr_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // engine registers; bus logic starts over while the oscillator is stopped
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            ptr_q <= 4'h0;
            tx_q <= 8'h00;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            ptr_q <= ptr_d;
            tx_q <= tx_d;
        end
    end

    // receive shifter samples the data line on each rising clock edge
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            rx_q <= 8'h00;
        end else if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_s};
        end
    end

    // direction bit is latched when the address byte completes
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            rw_q <= 1'b0;
        end else if (state_q == ST_ADDR && scl_fall && byte_full) begin
            rw_q <= rx_q[0];
        end
    end

    // data-line pull-down follows the next state so it moves with the low clock
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_d)
                ST_ADDR_ACK, ST_WORD_ACK, ST_WDATA_ACK: begin
                    sda_oe_q <= 1'b1;
                end
                ST_RDATA: begin
                    sda_oe_q <= ~tx_d[7];
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;

    // byte port into the bank; one write per acknowledged data byte
    assign reg_bus.wr_en = (state_q == ST_WDATA) && scl_fall && byte_full && !start_det
        && !stop_det;
    assign reg_bus.addr = ptr_q;
    assign reg_bus.wdata = rx_q;

    // register storage; the layout lives in the mask and reset tables
    rtc_reg_bank u_bank (
        .ref_clk   (ref_clk),
        .rst       (core_rst),
        .bus       (reg_bus),
        .alarm_set (alarm_match),
        .timer_set (timer_expired),
        .vlow_set  (vlow_s),
        .regs_q    (regs_q)
    );

    // interrupt is the or of the enabled flags; pulse shaping sits downstream
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            int_oe_q <= 1'b0;
        end else begin
            int_oe_q <= (regs_q[ADDR_CTRL_TWO][BIT_ALM] & regs_q[ADDR_CTRL_TWO][BIT_ALM_IE])
                | (regs_q[ADDR_CTRL_TWO][BIT_TMR] & regs_q[ADDR_CTRL_TWO][BIT_TMR_IE]);
        end
    end

    assign int_out = 1'b0;
    assign int_oe = int_oe_q;

    // stop bit clears the divider chain; the 32.768 kHz output keeps running
    assign divider_clear = regs_q[ADDR_CTRL_ONE][BIT_STOP];

    // control fields straight from register flops
    assign factory_test = regs_q[ADDR_CTRL_ONE][BIT_TEST];
    assign factory_test_c_bit = regs_q[ADDR_CTRL_ONE][BIT_TEST_C];
    assign timer_irq_level_or_pulse = regs_q[ADDR_CTRL_TWO][BIT_IRQ_MODE];

    // alarm enables, one per alarm register
    assign alarm_condition_enable = {regs_q[ADDR_WDAY_ALARM][BIT_ALM_EN],
        regs_q[ADDR_DAY_ALARM][BIT_ALM_EN], regs_q[ADDR_HOUR_ALARM][BIT_ALM_EN],
        regs_q[ADDR_MIN_ALARM][BIT_ALM_EN]};

    // clock output control
    assign clock_output_disable = regs_q[ADDR_CLKOUT_CTRL][BIT_CKO_OFF];
    assign clock_output_freq_sel = regs_q[ADDR_CLKOUT_CTRL][BIT_SEL_HI:BIT_SEL_LO];

    // timer control and value
    assign timer_enable_bit = regs_q[ADDR_TIMER_CTRL][BIT_TMR_EN];
    assign timer_source_sel = regs_q[ADDR_TIMER_CTRL][BIT_SEL_HI:BIT_SEL_LO];
    assign timer_countdown_value = regs_q[ADDR_TIMER_COUNT];

endmodule : rtc_calendar_regs

// ### rtl/rtc_pkg.sv
// rtc_pkg: register map, field positions and reset values of the clock/calendar
// assumes: an 8-bit register file of sixteen entries behind a two-wire slave port
package rtc_pkg;

    // register addresses, one byte each
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
    localparam logic [3:0] ADDR_SECONDS = 4'h2;
    localparam logic [3:0] ADDR_MINUTES = 4'h3;
    localparam logic [3:0] ADDR_HOURS = 4'h4;
    localparam logic [3:0] ADDR_DAYS = 4'h5;
    localparam logic [3:0] ADDR_WEEKDAYS = 4'h6;
    localparam logic [3:0] ADDR_MONTHS = 4'h7;
    localparam logic [3:0] ADDR_YEARS = 4'h8;
    localparam logic [3:0] ADDR_MIN_ALARM = 4'h9;
    localparam logic [3:0] ADDR_HOUR_ALARM = 4'ha;
    localparam logic [3:0] ADDR_DAY_ALARM = 4'hb;
    localparam logic [3:0] ADDR_WDAY_ALARM = 4'hc;
    localparam logic [3:0] ADDR_CLKOUT_CTRL = 4'hd;
    localparam logic [3:0] ADDR_TIMER_CTRL = 4'he;
    localparam logic [3:0] ADDR_TIMER_COUNT = 4'hf;

    // bit positions inside the registers
    localparam int BIT_TEST = 7;
    localparam int BIT_STOP = 5;
    localparam int BIT_TEST_C = 3;
    localparam int BIT_IRQ_MODE = 4;
    localparam int BIT_ALM = 3;
    localparam int BIT_TMR = 2;
    localparam int BIT_ALM_IE = 1;
    localparam int BIT_TMR_IE = 0;
    localparam int BIT_LOWV = 7;
    localparam int BIT_ALM_EN = 7;
    localparam int BIT_CKO_OFF = 7;
    localparam int BIT_TMR_EN = 7;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_SEL_LO = 0;

    // implemented bits per register, index 15 first; cleared bits hold no storage
    localparam logic [15:0][7:0] REG_MASK = {
        8'hff, 8'h83, 8'h83, 8'h87, 8'hbf, 8'hbf, 8'hff, 8'hff,
        8'h9f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'h1f, 8'ha8};

    // values taken under reset, index 15 first
    localparam logic [15:0][7:0] REG_RST = {
        8'h00, 8'h03, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h08};

    // two-wire slave byte length and seven-bit slave address width
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SLAVE_ADDR_W = 7;

endpackage : rtc_pkg

// ### rtl/rtc_reg_if.sv
// rtc_reg_if: byte port between the two-wire engine and the register bank
// assumes: both ends on ref_clk; write is a one-cycle strobe
`timescale 1ns/10ps
interface rtc_reg_if;
    logic wr_en;        // one-cycle write strobe
    logic [3:0] addr;   // register pointer
    logic [7:0] wdata;  // byte to store
    logic [7:0] rdata;  // registered read of addr

    modport engine (output wr_en, output addr, output wdata, input rdata);
    modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface : rtc_reg_if

// ### rtl/rtc_pin_sync.sv
// rtc_pin_sync: three-stage synchroniser with a two-stage agreement filter
// assumes: raw input is asynchronous to ref_clk
`timescale 1ns/10ps
module rtc_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // raw pin and filtered level
    input wire logic raw_in,
    output logic level_q
);
    logic meta_q;   // first stage, read only by stage two
    logic s2_q;     // second stage
    logic s3_q;     // third stage

    // shift chain; the output only moves once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            meta_q <= raw_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s2_q;
            end
        end
    end
endmodule : rtc_pin_sync

// ### rtl/rtc_reg_bank.sv
// rtc_reg_bank: sixteen byte registers with masks, sticky flags and reset values
// assumes: rst already merges the external reset and the oscillator-stop reset
`timescale 1ns/10ps
module rtc_reg_bank
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // byte port from the two-wire engine
    rtc_reg_if.bank bus,
    // hardware flag sources
    input wire logic alarm_set,
    input wire logic timer_set,
    input wire logic vlow_set,
    // whole register image for the control outputs
    output logic [15:0][7:0] regs_q
);
    logic [15:0][7:0] regs_d;   // next register image

    // write merge and flag setting; a set in the clear cycle still wins
    always_comb begin
        regs_d = regs_q;
        if (bus.wr_en) begin
            regs_d[bus.addr] = bus.wdata & REG_MASK[bus.addr];
            if (bus.addr == ADDR_CTRL_TWO) begin
                // flags only ever clear on a written zero
                regs_d[ADDR_CTRL_TWO][BIT_ALM] &= regs_q[ADDR_CTRL_TWO][BIT_ALM];
                regs_d[ADDR_CTRL_TWO][BIT_TMR] &= regs_q[ADDR_CTRL_TWO][BIT_TMR];
            end
        end
        if (alarm_set) begin
            regs_d[ADDR_CTRL_TWO][BIT_ALM] = 1'b1;
        end
        if (timer_set) begin
            regs_d[ADDR_CTRL_TWO][BIT_TMR] = 1'b1;
        end
        if (vlow_set) begin
            regs_d[ADDR_SECONDS][BIT_LOWV] = 1'b1;
        end
    end

    // storage; reset clears all but the documented set-to-one bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regs_q <= REG_RST;
        end else begin
            regs_q <= regs_d;
        end
    end

    // registered read port; unimplemented bits are never stored so read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus.rdata <= 8'h00;
        end else begin
            bus.rdata <= regs_q[bus.addr] & REG_MASK[bus.addr];
        end
    end
endmodule : rtc_reg_bank

// ### dv/rtc_calendar_regs_asserts.sv
// rtc_calendar_regs_asserts: port checks of the register block
// assumes: bound to rtc_calendar_regs, one ref_clk domain, rst synchronous
`timescale 1ns/10ps
module rtc_calendar_regs_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // disturbing inputs
    input wire logic scl_in,
    input wire logic osc_stopped_in,
    // pins and control bits
    input wire logic sda_oe,
    input wire logic int_oe,
    input wire logic divider_clear,
    input wire logic factory_test,
    input wire logic factory_test_c_bit,
    input wire logic [3:0] alarm_condition_enable,
    input wire logic clock_output_disable,
    input wire logic [1:0] clock_output_freq_sel,
    input wire logic timer_enable_bit,
    input wire logic [1:0] timer_source_sel,
    input wire logic [7:0] timer_countdown_value
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // cycles since scl moved or osc stopped; saturates
    logic [3:0] quiet_q;
    always_ff @(posedge ref_clk) begin
        if (rst || osc_stopped_in || scl_in != $past(scl_in)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // bus clock held high
    sequence scl_held_high;
        (scl_in && !osc_stopped_in)[*8];
    endsequence
    // osc stop long enough to pass the synchroniser
    sequence osc_held;
        osc_stopped_in[*7];
    endsequence
    a_reset_ones: assert property ($fell(rst) |-> clock_output_disable &&
        alarm_condition_enable == 4'hf && timer_source_sel == 2'h3 && factory_test_c_bit)
        else $error("reset left a set bit clear");
    a_reset_zeros: assert property ($fell(rst) |-> !factory_test && !divider_clear &&
        !timer_enable_bit && clock_output_freq_sel == 2'h0 && timer_countdown_value == 8'h00
        && !int_oe && !sda_oe) else $error("reset left a clear bit set");
    a_osc_reset: assert property (osc_held |-> clock_output_disable && !sda_oe &&
        alarm_condition_enable == 4'hf && timer_countdown_value == 8'h00)
        else $error("osc stop missed reset");
    a_timer_hold_idle: assert property (quiet_q >= 4'ha |-> $stable({timer_countdown_value,
        timer_source_sel, timer_enable_bit})) else $error("timer bits moved while idle");
    a_ctrl_hold_idle: assert property (quiet_q >= 4'ha |-> $stable({factory_test,
        divider_clear, alarm_condition_enable, clock_output_disable, clock_output_freq_sel}))
        else $error("control bits moved while idle");
    a_int_hold_idle: assert property (quiet_q >= 4'ha |-> !$fell(int_oe))
        else $error("interrupt dropped without a write");
    a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 3) == 1'b0)
        else $error("data driven outside clock low");
    a_data_steady: assert property (scl_held_high |-> $stable(sda_oe))
        else $error("data moved while clock high");
endmodule : rtc_calendar_regs_asserts

// ### dv/rtc_tw_master.sv
// rtc_tw_master: behavioural two-wire bus master
// assumes: the bench resolves the open-drain data line with a pull-up
`timescale 1ns/10ps
module rtc_tw_master (
    // clock
    input wire logic ref_clk,
    // resolved data line
    input wire logic sda_line,
    // bus clock and data pull-down
    output logic scl_q,
    output logic sda_low_q
);
    // idle bus: clock high, data released
    initial begin
        scl_q = 1'b1;
        sda_low_q = 1'b0;
    end
    // wait n reference cycles
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // one bit; clock low 12 cycles so the filtered slave keeps up
    task automatic bit_x(input logic b, output logic r);
        sda_low_q <= !b;
        tick(6);
        scl_q <= 1'b1;
        tick(12);
        r = sda_line;
        scl_q <= 1'b0;
        tick(6);
    endtask : bit_x
    // (repeated) start; accesses last microseconds
    task automatic start();
        sda_low_q <= 1'b0;
        tick(6);
        scl_q <= 1'b1;
        tick(12);
        sda_low_q <= 1'b1;
        tick(12);
        scl_q <= 1'b0;
        tick(6);
    endtask : start
    // stop; bus left idle
    task automatic stop();
        sda_low_q <= 1'b1;
        tick(6);
        scl_q <= 1'b1;
        tick(12);
        sda_low_q <= 1'b0;
        tick(12);
    endtask : stop
    // byte msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
        output logic sack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(!mack, r);
        sack = !r;
    endtask : xfer
endmodule : rtc_tw_master

// ### dv/test_rtc_calendar_regs.sv
// test_rtc_calendar_regs: register map bench against a queue-free byte model
// assumes: package, master and checker compiled first
`timescale 1ns/10ps
module test_rtc_calendar_regs;
    import rtc_pkg::*;
    localparam logic [6:0] SA = 7'h51; // bus address, arbitrary
    logic ref_clk, rst, osc, vlow, alarm_match, timer_expired, scl, m_low, sda_oe, int_oe;
    logic [21:0] ctl; // control outputs, packed
    logic [7:0] mdl [16]; // expected register image
    int bad_count, samples_checked, cycles, seed;
    wire sda_line = !(m_low || sda_oe); // pulled-up open-drain wire
    rtc_tw_master i_master (.ref_clk(ref_clk), .sda_line(sda_line), .scl_q(scl),
        .sda_low_q(m_low));
    rtc_calendar_regs #(.SLAVE_ADDR(SA)) i_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .osc_stopped_in(osc),
        .supply_low_in(vlow), .alarm_match(alarm_match), .timer_expired(timer_expired),
        .int_out(), .int_oe(int_oe), .divider_clear(ctl[21]), .factory_test(ctl[20]),
        .factory_test_c_bit(ctl[19]), .timer_irq_level_or_pulse(ctl[18]),
        .alarm_condition_enable(ctl[17:14]), .clock_output_disable(ctl[13]),
        .clock_output_freq_sel(ctl[12:11]), .timer_enable_bit(ctl[10]),
        .timer_source_sel(ctl[9:8]), .timer_countdown_value(ctl[7:0]));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // hang guard; the run needs about 31k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // image after reset
    task automatic reset_mdl();
        foreach (mdl[i]) mdl[i] = (i >= 9 && i <= 13) ? 8'h80 : 8'h00;
        mdl[0] = 8'h08;
        mdl[2] = 8'h80;
        mdl[14] = 8'h03;
    endtask : reset_mdl
    // flags only clear on a written zero
    task automatic mset(input logic [3:0] a, input logic [7:0] d);
        if (a == ADDR_CTRL_TWO) d = (d & 8'hf3) | (d & mdl[1] & 8'h0c);
        mdl[a] = d & REG_MASK[a];
    endtask : mset
    task automatic chk_ctl();
        chk(32'(ctl), 32'({mdl[0][5], mdl[0][7], mdl[0][3], mdl[1][4], mdl[12][7],
            mdl[11][7], mdl[10][7], mdl[9][7], mdl[13][7], mdl[13][1:0], mdl[14][7],
            mdl[14][1:0], mdl[15]}));
        chk(32'(int_oe), 32'((mdl[1][3] & mdl[1][1]) | (mdl[1][2] & mdl[1][0])));
    endtask : chk_ctl
    // n bytes from pointer a; random data when n > 1
    task automatic wr(input logic [6:0] sa, input logic [3:0] a, input int n,
        input logic [7:0] d);
        logic [7:0] q;
        logic ack;
        i_master.start();
        i_master.xfer({sa, 1'b0}, 1'b0, q, ack);
        chk(32'(ack), 32'(sa == SA));
        i_master.xfer({4'h0, a}, 1'b0, q, ack);
        for (int i = 0; i < n; i++) begin
            if (n > 1) d = 8'($random(seed));
            if (a < 4'h2) d &= REG_MASK[a];
            i_master.xfer(d, 1'b0, q, ack);
            if (sa == SA) mset(a, d);
            a++;
        end
        i_master.stop();
    endtask : wr
    task automatic rd(input logic [3:0] a, input int n, input bit setp);
        logic [7:0] q;
        logic ack;
        if (setp) begin
            i_master.start();
            i_master.xfer({SA, 1'b0}, 1'b0, q, ack);
            i_master.xfer({4'h0, a}, 1'b0, q, ack);
        end
        i_master.start();
        i_master.xfer({SA, 1'b1}, 1'b0, q, ack);
        for (int i = 0; i < n; i++) begin
            i_master.xfer(8'hff, i < n - 1, q, ack);
            chk(32'(q), 32'(mdl[a]));
            a++;
        end
        i_master.stop();
    endtask : rd
    // event pulse, then interrupt compare
    task automatic pulse(input bit tmr);
        repeat (12) @(posedge ref_clk);
        {timer_expired, alarm_match} <= tmr ? 2'b10 : 2'b01;
        @(posedge ref_clk);
        {timer_expired, alarm_match} <= 2'b00;
        mdl[1][tmr ? 2 : 3] = 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_ctl();
    endtask : pulse
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    initial begin
        seed = 32'hf62d4dbc;
        {rst, osc, vlow, alarm_match, timer_expired} = 5'h10;
        reset_mdl();
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk_ctl();
        rd(4'h0, 17, 1'b0);
        repeat (2) begin
            wr(SA, ADDR_WDAY_ALARM, 16, 8'h00);
            chk_ctl();
            rd(ADDR_WDAY_ALARM, 16, 1'b1);
        end
        wr(SA, ADDR_CTRL_TWO, 1, 8'h03);
        pulse(1'b0);
        pulse(1'b1);
        wr(SA, ADDR_CTRL_TWO, 1, 8'h0b);
        rd(ADDR_CTRL_TWO, 1, 1'b1);
        chk_ctl();
        wr(SA, ADDR_CTRL_TWO, 1, 8'h03);
        chk_ctl();
        wr(SA, ADDR_SECONDS, 1, 8'h59);
        vlow <= 1'b1;
        repeat (8) @(posedge ref_clk);
        vlow <= 1'b0;
        mdl[2][7] = 1'b1;
        wr(7'h52, ADDR_YEARS, 1, 8'h55);
        rd(ADDR_SECONDS, 7, 1'b1);
        osc <= 1'b1;
        repeat (10) @(posedge ref_clk);
        osc <= 1'b0;
        reset_mdl();
        repeat (8) @(posedge ref_clk);
        chk_ctl();
        rd(4'h0, 16, 1'b1);
        summarize();
    end
endmodule : test_rtc_calendar_regs
bind rtc_calendar_regs rtc_calendar_regs_asserts i_chk (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl_in), .osc_stopped_in(osc_stopped_in), .sda_oe(sda_oe), .int_oe(int_oe),
    .divider_clear(divider_clear), .factory_test(factory_test),
    .factory_test_c_bit(factory_test_c_bit), .alarm_condition_enable(alarm_condition_enable),
    .clock_output_disable(clock_output_disable), .clock_output_freq_sel(clock_output_freq_sel),
    .timer_enable_bit(timer_enable_bit), .timer_source_sel(timer_source_sel),
    .timer_countdown_value(timer_countdown_value));
